//--- verilog/error_corrector_host_defines.svh
/*
  Constants for the controller that drives the 32-bit error corrector through its pins.
  Assumes the error corrector is an external clockless part whose pins are sampled on mclk_in.
*/
`ifndef ERROR_CORRECTOR_HOST_DEFINES_SVH
`define ERROR_CORRECTOR_HOST_DEFINES_SVH
`define MODE_GEN      2'b00
`define MODE_DIAG     2'b01
`define MODE_FLAG     2'b10
`define MODE_CORRECT  2'b11
`define SETTLE_NS     40
`define CLK_NS        50
`define SETTLE_CYC    (((`SETTLE_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define DATA_W        32
`define CHECK_W       7
`define BYTE_N        4
`define STORE_DEPTH   16
`define ADDR_W        4
`endif

//--- verilog/error_corrector_host_pkg.sv
/*
  Types for the error corrector controller.
  Assumes error_corrector_host_defines.svh is included before use.
*/
package error_corrector_host_pkg;
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WGEN,
    ST_WSTORE,
    ST_RFLAG,
    ST_RLATCH,
    ST_RHOLD,
    ST_RCORR,
    ST_MGEN,
    ST_DIAG,
    ST_DONE
  } host_state_t;
  typedef enum logic [1:0] {
    OP_WRITE,
    OP_READ,
    OP_MODIFY,
    OP_DIAG
  } host_op_t;
endpackage

//--- verilog/store_mem.sv
/*
  Small memory holding 39-bit stored words (data plus check).
  Assumes a single clock; read data is registered.
*/
`timescale 1ns/10ps
`include "error_corrector_host_defines.svh"
module store_mem #(
  parameter int WIDTH = `DATA_W + `CHECK_W,
  parameter int DEPTH = `STORE_DEPTH,
  parameter int AW    = `ADDR_W
) (
  input  wire logic             mclk_in,
  input  wire logic             ce_in,
  input  wire logic             wr_in,
  input  wire logic [AW-1:0]    addr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  output logic      [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  always_ff @(posedge mclk_in)
  begin
    if (ce_in)
    begin
      if (wr_in)
        mem_r[addr_in] <= wdata_in;
      rdata_out <= mem_r[addr_in];
    end
  end
endmodule

//--- verilog/error_corrector_host.sv
/*
  Controller that runs the external 32-bit error corrector for write, read,
  byte merge and diagnostic cycles, keeping stored words in a local memory.
  Assumes all device outputs are stable and synchronous to mclk_in.
*/
`timescale 1ns/10ps
`include "error_corrector_host_defines.svh"
module error_corrector_host #(
  parameter int SETTLE = `SETTLE_CYC
) (
  input  wire logic                         mclk_in,
  input  wire logic                         srst_in,
  input  wire logic                         ce_in,
  input  wire logic                         req_in,
  input  wire error_corrector_host_pkg::host_op_t      op_in,
  input  wire logic [`ADDR_W-1:0]           addr_in,
  input  wire logic [`DATA_W-1:0]           wdata_in,
  input  wire logic [`BYTE_N-1:0]           byte_sel_in,
  input  wire logic [`CHECK_W-1:0]          diag_check_in,
  output logic                              busy_out,
  output logic                              done_out,
  output logic [`DATA_W-1:0]                rdata_out,
  output logic [`CHECK_W-1:0]               syndrome_out,
  output logic                              single_err_out,
  output logic                              multi_err_out,
  output logic                              mode_select0,
  output logic                              mode_select1,
  output logic                              output_latch_hold,
  output logic [`BYTE_N-1:0]                byte_drive_enable_n,
  output logic                              check_port_drive_enable_n,
  input  wire logic [`DATA_W-1:0]           data_port_in,
  output logic [`DATA_W-1:0]                data_port_out,
  output logic [`DATA_W/8-1:0]              data_port_oe,
  input  wire logic [`CHECK_W-1:0]          check_port_in,
  output logic [`CHECK_W-1:0]               check_port_out,
  output logic                              check_port_oe,
  input  wire logic                         single_error_flag_n,
  input  wire logic                         multi_error_flag_n
);
  import error_corrector_host_pkg::*;
  localparam int CW = $clog2(SETTLE + 2);
  host_state_t                state_r, state_nxt;
  host_op_t                   op_r, op_nxt;
  logic [CW-1:0]              cnt_r, cnt_nxt;
  logic [1:0]                 mode_r, mode_nxt;
  logic                       hold_r, hold_nxt;
  logic [`BYTE_N-1:0]         ben_r, ben_nxt;
  logic                       cben_r, cben_nxt;
  logic [`DATA_W-1:0]         dout_r, dout_nxt;
  logic [`BYTE_N-1:0]         doe_r, doe_nxt;
  logic [`CHECK_W-1:0]        cout_r, cout_nxt;
  logic                       coe_r, coe_nxt;
  logic [`ADDR_W-1:0]         addr_r, addr_nxt;
  logic [`DATA_W-1:0]         wd_r, wd_nxt;
  logic [`BYTE_N-1:0]         bsel_r, bsel_nxt;
  logic [`DATA_W-1:0]         rd_r, rd_nxt;
  logic [`CHECK_W-1:0]        syn_r, syn_nxt;
  logic                       serr_r, serr_nxt;
  logic                       multi_error_flag_n_r, multi_error_flag_n_nxt;
  logic                       done_r, done_nxt;
  logic                       mem_wr;
  logic [`DATA_W+`CHECK_W-1:0] mem_rd;
  logic [`DATA_W-1:0]         merged;
  logic                       settled;
  logic [`ADDR_W-1:0]         mem_addr;

  store_mem u_mem (
    .mclk_in   (mclk_in),
    .ce_in     (ce_in),
    .wr_in     (mem_wr),
    .addr_in   (mem_addr),
    .wdata_in  ({check_port_in, data_port_in}),
    .rdata_out (mem_rd)
  );

  assign settled = (cnt_r == CW'(SETTLE));
  // Memory reads the requested word while idle so it is ready on the first drive cycle
  assign mem_addr = (state_r == ST_IDLE) ? addr_in : addr_r;
  // Byte merge: chosen bytes come from the user, the rest pass from the latch
  genvar g;
  generate
    for (g = 0; g < `BYTE_N; g++)
    begin : g_merge
      assign merged[g*8 +: 8] = bsel_r[g] ? wd_r[g*8 +: 8] : rd_r[g*8 +: 8];
      assign data_port_oe[g] = doe_r[g];
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;
    op_nxt    = op_r;
    cnt_nxt   = settled ? cnt_r : cnt_r + CW'(1);
    mode_nxt  = mode_r;
    hold_nxt  = hold_r;
    ben_nxt   = ben_r;
    cben_nxt  = cben_r;
    dout_nxt  = dout_r;
    doe_nxt   = doe_r;
    cout_nxt  = cout_r;
    coe_nxt   = coe_r;
    addr_nxt  = addr_r;
    wd_nxt    = wd_r;
    bsel_nxt  = bsel_r;
    rd_nxt    = rd_r;
    syn_nxt   = syn_r;
    serr_nxt  = serr_r;
    multi_error_flag_n_nxt  = multi_error_flag_n_r;
    done_nxt  = 1'b0;
    mem_wr    = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        {mode_nxt, hold_nxt, ben_nxt, cben_nxt} = {`MODE_FLAG, 1'b0, 4'hF, 1'b1};
        doe_nxt = 4'hF;
        coe_nxt = 1'b1;
        if (req_in)
        begin
          op_nxt   = op_in;
          addr_nxt = addr_in;
          wd_nxt   = wdata_in;
          bsel_nxt = byte_sel_in;
          cnt_nxt  = '0;
          if (op_in == OP_WRITE)
          begin
            mode_nxt = `MODE_GEN;
            cben_nxt = 1'b0;
            dout_nxt = wdata_in;
            doe_nxt  = 4'h0;
            state_nxt = ST_WGEN;
          end
          else if (op_in == OP_DIAG)
          begin
            mode_nxt = `MODE_DIAG;
            dout_nxt = wdata_in;
            doe_nxt  = 4'h0;
            cout_nxt = diag_check_in;
            coe_nxt  = 1'b0;
            state_nxt = ST_DIAG;
          end
          else
            state_nxt = ST_RFLAG;
        end
      end
      ST_WGEN:
        if (settled)
        begin
          mem_wr    = 1'b1;
          state_nxt = ST_WSTORE;
        end
      ST_WSTORE:
        state_nxt = ST_DONE;
      ST_RFLAG:
      begin
        // Word from memory drives the device pins in read-and-flag mode
        dout_nxt = mem_rd[`DATA_W-1:0];
        cout_nxt = mem_rd[`DATA_W +: `CHECK_W];
        doe_nxt  = 4'h0;
        coe_nxt  = 1'b0;
        if (settled)
        begin
          serr_nxt  = ~single_error_flag_n;
          multi_error_flag_n_nxt  = ~multi_error_flag_n;
          mode_nxt  = `MODE_CORRECT;
          cnt_nxt   = '0;
          state_nxt = ST_RLATCH;
        end
      end
      ST_RLATCH:
        if (settled)
        begin
          doe_nxt   = 4'hF;
          coe_nxt   = 1'b1;
          cnt_nxt   = '0;
          state_nxt = ST_RHOLD;
        end
      ST_RHOLD:
        if (settled)
        begin
          hold_nxt  = 1'b1;
          ben_nxt   = 4'h0;
          cben_nxt  = 1'b0;
          cnt_nxt   = '0;
          state_nxt = ST_RCORR;
        end
      ST_RCORR:
        if (settled)
        begin
          rd_nxt  = data_port_in;
          syn_nxt = check_port_in;
          ben_nxt = 4'hF;
          cben_nxt = 1'b1;
          cnt_nxt = '0;
          if (op_r == OP_MODIFY && !multi_error_flag_n_r)
          begin
            mode_nxt  = `MODE_GEN;
            ben_nxt   = bsel_r;
            cben_nxt  = 1'b0;
            state_nxt = ST_MGEN;
          end
          else
            state_nxt = ST_DONE;
        end
      ST_MGEN:
      begin
        dout_nxt = merged;
        doe_nxt  = ~bsel_r;
        if (settled)
        begin
          mem_wr    = 1'b1;
          rd_nxt    = data_port_in;
          state_nxt = ST_DONE;
        end
      end
      ST_DIAG:
        if (settled)
        begin
          serr_nxt  = ~single_error_flag_n;
          multi_error_flag_n_nxt  = ~multi_error_flag_n;
          mode_nxt  = `MODE_CORRECT;
          cnt_nxt   = '0;
          state_nxt = ST_RLATCH;
          op_nxt    = OP_READ;
        end
      default:
      begin
        done_nxt  = 1'b1;
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state_r <= ST_IDLE;
      op_r    <= OP_WRITE;
      cnt_r   <= '0;
      mode_r  <= `MODE_FLAG;
      hold_r  <= 1'b0;
      ben_r   <= 4'hF;
      cben_r  <= 1'b1;
      dout_r  <= '0;
      doe_r   <= 4'hF;
      cout_r  <= '0;
      coe_r   <= 1'b1;
      addr_r  <= '0;
      wd_r    <= '0;
      bsel_r  <= '0;
      rd_r    <= '0;
      syn_r   <= '0;
      serr_r  <= 1'b0;
      multi_error_flag_n_r  <= 1'b0;
      done_r  <= 1'b0;
    end
    else if (ce_in)
    begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      mode_r  <= mode_nxt;
      hold_r  <= hold_nxt;
      ben_r   <= ben_nxt;
      cben_r  <= cben_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= doe_nxt;
      cout_r  <= cout_nxt;
      coe_r   <= coe_nxt;
      addr_r  <= addr_nxt;
      wd_r    <= wd_nxt;
      bsel_r  <= bsel_nxt;
      rd_r    <= rd_nxt;
      syn_r   <= syn_nxt;
      serr_r  <= serr_nxt;
      multi_error_flag_n_r  <= multi_error_flag_n_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy_out                  = (state_r != ST_IDLE);
  assign done_out                  = done_r;
  assign rdata_out                 = rd_r;
  assign syndrome_out              = syn_r;
  assign single_err_out            = serr_r;
  assign multi_err_out             = multi_error_flag_n_r;
  assign {mode_select1, mode_select0} = mode_r;
  assign output_latch_hold         = hold_r;
  assign byte_drive_enable_n       = ben_r;
  assign check_port_drive_enable_n = cben_r;
  assign data_port_out             = dout_r;
  assign check_port_out            = cout_r;
  assign check_port_oe             = coe_r;

  gen_mode_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state_r == ST_WGEN) |-> (mode_r == `MODE_GEN))
    else $error("write not in generate mode");
  corr_mode_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state_r == ST_RCORR) |-> (mode_r == `MODE_CORRECT) && !cben_r && hold_r)
    else $error("correction step not set up");
  pin_clash_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    !cben_r |-> coe_r)
    else $error("check port driven by both ends");
  byte_clash_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    (~ben_r & ~doe_r) == 4'h0)
    else $error("data byte driven by both ends");
  latch_hold_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    $rose(hold_r) |-> $past(state_r) == ST_RHOLD)
    else $error("output latch held outside hold step");
  store_write_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    mem_wr && ce_in |-> settled && !cben_r && mode_r == `MODE_GEN)
    else $error("store without generated check word");
  flag_take_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    ce_in && state_r == ST_RFLAG && settled |=> serr_r == $past(!single_error_flag_n))
    else $error("single flag not captured");
  done_pulse_a: assert property (@(posedge mclk_in) disable iff (srst_in)
    done_r |=> !done_r)
    else $error("done longer than one cycle");
endmodule

//--- testbench/corrector_model.sv
/*
  Behavioural pin model of the 32-bit error corrector: input latches, code, flags, output latch.
  Assumes the bench resolves the shared data and check wires and feeds the levels back here.
*/
`timescale 1ns/10ps
module corrector_model (
  input  wire logic        mode_select0,
  input  wire logic        mode_select1,
  input  wire logic        output_latch_hold,
  input  wire logic        check_port_drive_enable_n,
  input  wire logic [31:0] data_port_in,
  input  wire logic [6:0]  check_port_in,
  output logic      [31:0] data_drv_out,
  output logic      [6:0]  check_drv_out,
  output logic             single_error_flag_n,
  output logic             multi_error_flag_n
);
  logic [6:0]  col [32];
  logic [31:0] din;
  logic [31:0] fixed;
  logic [31:0] olat;
  logic [6:0]  cin;
  logic [6:0]  g_db;
  logic [6:0]  g_in;
  logic [6:0]  syn;
  logic [1:0]  mode;
  assign mode = {mode_select1, mode_select0};
  // Odd-weight columns give single correction and double detection
  always_comb
  begin
    int n;
    n = 0;
    for (int v = 0; v < 128; v++)
      if ($countones(v[6:0]) == 3 && n < 32)
      begin
        col[n] = v[6:0];
        n++;
      end
  end
  always_comb
  begin
    g_db = 7'h07;
    g_in = 7'h07;
    for (int i = 0; i < 32; i++)
    begin
      if (data_port_in[i]) g_db = g_db ^ col[i];
      if (din[i]) g_in = g_in ^ col[i];
    end
    syn = g_in ^ cin;
    fixed = din;
    for (int i = 0; i < 32; i++)
      if (syn == col[i]) fixed[i] = ~din[i];
  end
  always_latch
  begin
    if (mode == 2'b10 || mode == 2'b01) din = data_port_in;
    if (mode == 2'b10 || mode == 2'b01) cin = check_port_in;
    if (!output_latch_hold) olat = fixed;
  end
  assign data_drv_out = olat;
  assign check_drv_out = (mode == 2'b00) ? g_db : (mode == 2'b11) ? syn : cin;
  assign single_error_flag_n = (mode == 2'b00) || (syn == 7'h00);
  assign multi_error_flag_n = (mode == 2'b00) || (syn == 7'h00) || $countones(syn) % 2 == 1;
endmodule

//--- testbench/tb.sv
/*
  Self-checking bench for the error corrector controller with a pin model of the device.
  Assumes the design's default settle count and its registered done pulse.
*/
`timescale 1ns/10ps
`include "error_corrector_host_defines.svh"
module tb;
  import error_corrector_host_pkg::*;
  logic        mclk_in, srst_in, ce_in, req_in;
  host_op_t    op_in;
  logic [3:0]  addr_in, byte_sel_in, byte_drive_enable_n, data_port_oe, modes_seen;
  logic [31:0] wdata_in, rdata_out, data_port_out, db_wire, db_dev, db_last, exp_d;
  logic [6:0]  diag_check_in, syndrome_out, check_port_out, cb_wire, cb_dev, cb_last, last_gen;
  logic        busy_out, done_out, single_err_out, multi_err_out, mode_select0, mode_select1;
  logic        output_latch_hold, check_port_drive_enable_n, check_port_oe, err_n, multi_error_flag_n_n;
  int          err_count;
  int          checked;
  error_corrector_host error_corrector_host_inst (.mclk_in(mclk_in), .srst_in(srst_in), .ce_in(ce_in), .req_in(req_in),
    .op_in(op_in), .addr_in(addr_in), .wdata_in(wdata_in), .byte_sel_in(byte_sel_in),
    .diag_check_in(diag_check_in), .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out),
    .syndrome_out(syndrome_out), .single_err_out(single_err_out), .multi_err_out(multi_err_out),
    .mode_select0(mode_select0), .mode_select1(mode_select1), .output_latch_hold(output_latch_hold),
    .byte_drive_enable_n(byte_drive_enable_n), .check_port_drive_enable_n(check_port_drive_enable_n),
    .data_port_in(db_wire), .data_port_out(data_port_out), .data_port_oe(data_port_oe),
    .check_port_in(cb_wire), .check_port_out(check_port_out), .check_port_oe(check_port_oe),
    .single_error_flag_n(err_n), .multi_error_flag_n(multi_error_flag_n_n));
  corrector_model corrector_model_inst (.mode_select0(mode_select0), .mode_select1(mode_select1),
    .output_latch_hold(output_latch_hold), .check_port_drive_enable_n(check_port_drive_enable_n),
    .data_port_in(db_wire), .check_port_in(cb_wire), .data_drv_out(db_dev), .check_drv_out(cb_dev),
    .single_error_flag_n(err_n), .multi_error_flag_n(multi_error_flag_n_n));
  // Released wires show the inverse of their last level
  always_comb
    for (int b = 0; b < 4; b++)
      db_wire[8*b +: 8] = !byte_drive_enable_n[b] ? db_dev[8*b +: 8] :
                          !data_port_oe[b] ? data_port_out[8*b +: 8] : ~db_last[8*b +: 8];
  assign cb_wire = !check_port_drive_enable_n ? cb_dev : !check_port_oe ? check_port_out : ~cb_last;
  always @(posedge mclk_in)
  begin
    db_last <= db_wire;
    cb_last <= cb_wire;
    modes_seen[{mode_select1, mode_select0}] <= 1'b1;
    if (!check_port_drive_enable_n && {mode_select1, mode_select0} == 2'b00) last_gen <= cb_wire;
  end
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic start_op(input host_op_t o, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [6:0] c);
    @(posedge mclk_in);
    #1;
    op_in = o;
    addr_in = a;
    wdata_in = d;
    byte_sel_in = s;
    diag_check_in = c;
    req_in = 1'b1;
    @(posedge mclk_in);
    #1;
    req_in = 1'b0;
    chk("busy", busy_out, 1);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 200)
    begin
      @(posedge mclk_in);
      #1;
      n++;
    end
    if (n == 200)
    begin
      err_count++;
      complete_run();
    end
  endtask
  task automatic run_op(input host_op_t o, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    start_op(o, a, d, s, 7'h00);
    wait_done();
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] d);
    run_op(OP_READ, a, 32'h0, 4'h0);
    chk("rdata", rdata_out, d);
    chk("flags", {single_err_out, multi_err_out}, 0);
    chk("syndrome", syndrome_out, 0);
  endtask
  task automatic dcase(input logic [31:0] d, input logic [6:0] c, input logic [1:0] f, input logic [31:0] e);
    start_op(OP_DIAG, 4'h0, d, 4'h0, c);
    wait_done();
    chk("diag flags", {single_err_out, multi_err_out}, f);
    chk("diag data", rdata_out, e);
  endtask
  initial
  begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    req_in = 1'b0;
    op_in = OP_WRITE;
    addr_in = 4'h0;
    wdata_in = 32'h0;
    byte_sel_in = 4'h0;
    diag_check_in = 7'h00;
    db_last = 32'h0;
    cb_last = 7'h00;
    modes_seen = 4'h0;
    err_count = 0;
    checked = 0;
    repeat (10) @(posedge mclk_in);
    #1;
    chk("reset pins", {mode_select1, mode_select0, output_latch_hold, byte_drive_enable_n,
        check_port_drive_enable_n, data_port_oe, check_port_oe, busy_out, done_out}, 32'h00004FFC);
    srst_in = 1'b0;
    run_op(OP_WRITE, 4'h0, 32'h0, 4'h0);
    chk("zero check word", last_gen, 7'h07);
    rd_chk(4'h0, 32'h0);
    for (int i = 3; i < 32; i += 8)
    begin
      run_op(OP_WRITE, i[3:0], 32'h12345678 ^ (32'h1 << i), 4'h0);
      rd_chk(i[3:0], 32'h12345678 ^ (32'h1 << i));
    end
    exp_d = 32'h11223344;
    run_op(OP_WRITE, 4'h1, exp_d, 4'h0);
    for (int s = 0; s < 16; s += 5)
    begin
      run_op(OP_MODIFY, 4'h1, 32'hAABBCCDD + s, s[3:0]);
      for (int b = 0; b < 4; b++)
        if (s[b]) exp_d[8*b +: 8] = (32'hAABBCCDD + s) >> (8*b);
      rd_chk(4'h1, exp_d);
    end
    dcase(32'h0, 7'h07, 2'b00, 32'h0);
    for (int i = 0; i < 32; i += 15)
      dcase(32'h1 << i, 7'h07, 2'b10, 32'h0);
    for (int j = 0; j < 7; j++)
    begin
      dcase(32'h0, 7'h07 ^ (7'h01 << j), 2'b10, 32'h0);
      chk("check bit syndrome", syndrome_out, 7'h01 << j);
    end
    dcase(32'h3, 7'h07, 2'b11, 32'h3);
    dcase(32'h1, 7'h06, 2'b11, 32'h1);
    dcase(32'h0, 7'h04, 2'b11, 32'h0);
    run_op(OP_DIAG, 4'h0, 32'h0, 4'h0);
    chk("all low flagged", single_err_out | multi_err_out, 1);
    start_op(OP_DIAG, 4'h0, 32'hFFFFFFFF, 4'h0, 7'h7F);
    wait_done();
    chk("all high flagged", single_err_out | multi_err_out, 1);
    start_op(OP_READ, 4'h1, 32'h0, 4'h0, 7'h00);
    ce_in = 1'b0;
    repeat (6)
    begin
      @(posedge mclk_in);
      #1;
      chk("frozen", {busy_out, done_out}, 2'b10);
    end
    ce_in = 1'b1;
    wait_done();
    chk("rdata after freeze", rdata_out, exp_d);
    chk("modes used", modes_seen, 4'hF);
    complete_run();
  end
endmodule
